//--- design/drive_map_if.sv
// Interface between register bank and pin-level mapper
`timescale 1ns/1ns
`default_nettype none
interface drive_map_if;
  logic [7:0] lo;
  logic [7:0] hi;
  logic [7:0] pa;
  logic [7:0] pb;
  logic [7:0] pc;
  logic [7:0] pd;
  logic [7:0] pe;
  logic [7:0] pg;
  modport src (output lo, hi, input pa, pb, pc, pd, pe, pg);
  modport map (input lo, hi, output pa, pb, pc, pd, pe, pg);
endinterface
`default_nettype wire

//--- design/drive_pin_map.sv
// Expands drive-select bits to per-pin levels for the bonded pins
`timescale 1ns/1ns
`default_nettype none
module drive_pin_map
  import drive_pkg::*;
#(
  parameter logic [1:0] VARIANT = VARIANT_FULL
) (
  // Select bits in, pin levels out
  drive_map_if.map m
);
  // Bond masks of the chosen variant
  wire [7:0] bond_b = (VARIANT == VARIANT_SMALL) ? BOND_B_SMALL :
                      (VARIANT == VARIANT_MID)   ? BOND_B_MID : BOND_ALL;
  wire [7:0] bond_c = (VARIANT == VARIANT_SMALL) ? BOND_C_SMALL :
                      (VARIANT == VARIANT_MID)   ? BOND_C_MID : BOND_ALL;
  wire [7:0] bond_d = (VARIANT == VARIANT_SMALL) ? BOND_D_SMALL :
                      (VARIANT == VARIANT_MID)   ? BOND_D_MID : BOND_ALL;

  // Port A, every pin on every variant
  assign m.pa = {{4{m.lo[PA_HI_BIT]}}, {4{m.lo[PA_LO_BIT]}}};
  // Upper groups reach bonded pins only
  assign m.pb = {{4{m.lo[PB_HI_BIT]}}, {4{m.lo[PB_LO_BIT]}}} & bond_b;
  assign m.pc = {{4{m.lo[PC_HI_BIT]}}, {4{m.lo[PC_LO_BIT]}}} & bond_c;
  assign m.pd = {{4{m.lo[PD_HI_BIT]}}, {4{m.lo[PD_LO_BIT]}}} & bond_d;
  // Port E low nibble and port G
  assign m.pe = {8{m.hi[PE_LO_BIT]}} & BOND_E;
  assign m.pg = {{4{m.hi[PG_HI_BIT]}}, {4{m.hi[PG_LO_BIT]}}};
endmodule
`default_nettype wire

//--- design/drive_pkg.sv
// Constants for the port drive-strength register bank
package drive_pkg;
  // Register indexes on the plain register port
  localparam logic [3:0] DRIVE_LO_ADDR  = 4'h0;
  localparam logic [3:0] DRIVE_HI_ADDR  = 4'h1;
  // Reset values: every group at minimum drive
  localparam logic [7:0] DRIVE_LO_RESET = 8'h00;
  localparam logic [7:0] DRIVE_HI_RESET = 8'h00;
  // Implemented bits of the high register (port E low, port G both)
  localparam logic [7:0] DRIVE_HI_MASK  = 8'h31;
  // Field positions, low register
  localparam int PA_LO_BIT = 0;
  localparam int PA_HI_BIT = 1;
  localparam int PB_LO_BIT = 2;
  localparam int PB_HI_BIT = 3;
  localparam int PC_LO_BIT = 4;
  localparam int PC_HI_BIT = 5;
  localparam int PD_LO_BIT = 6;
  localparam int PD_HI_BIT = 7;
  // Field positions, high register
  localparam int PE_LO_BIT = 0;
  localparam int PG_LO_BIT = 4;
  localparam int PG_HI_BIT = 5;
  // Package variants
  localparam logic [1:0] VARIANT_SMALL = 2'h0;
  localparam logic [1:0] VARIANT_MID   = 2'h1;
  localparam logic [1:0] VARIANT_FULL  = 2'h2;
  // Bonded pins of ports B, C, D per variant
  localparam logic [7:0] BOND_B_SMALL  = 8'h1F;
  localparam logic [7:0] BOND_C_SMALL  = 8'h38;
  localparam logic [7:0] BOND_D_SMALL  = 8'hE7;
  localparam logic [7:0] BOND_B_MID    = 8'h5F;
  localparam logic [7:0] BOND_C_MID    = 8'h78;
  localparam logic [7:0] BOND_D_MID    = 8'hFF;
  localparam logic [7:0] BOND_ALL      = 8'hFF;
  // Port E has only its low nibble
  localparam logic [7:0] BOND_E        = 8'h0F;
  // Read data of an unmapped index
  localparam logic [7:0] READ_NONE     = 8'h00;
endpackage

//--- design/port_drive_strength_regs.sv
// Port drive-strength register bank with registered pad levels
`timescale 1ns/1ns
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Per-nibble drive select, ports A to E and G
// - Bit 0 minimum drive, 1 maximum
// - Low register bits 0-2: PA, PB low
// - Full variant bits 3-7: PB, PC, PD
// - Smaller variants drive only bonded pins
// - High register bits 0,4,5: PE, PG
// - Unimplemented high bits ignore writes, read zero
// - All select bits clear at reset
module port_drive_strength_regs
  import drive_pkg::*;
#(
  parameter logic [1:0] VARIANT = VARIANT_FULL
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  // Pad drive levels, one bit per pin
  output logic      [7:0] pa_drive,
  output logic      [7:0] pb_drive,
  output logic      [7:0] pc_drive,
  output logic      [7:0] pd_drive,
  output logic      [7:0] pe_drive,
  output logic      [7:0] pg_drive
);
  logic [7:0] drive_select_lo;
  logic [7:0] drive_select_hi;

  //////////////////////////////////////////////////////////////////////////////
  // Decode
  wire hit_lo = (addr == DRIVE_LO_ADDR);
  wire hit_hi = (addr == DRIVE_HI_ADDR);

  // Next select values on a write
  wire [7:0] next_lo = (wr_en && hit_lo) ? wr_data : drive_select_lo;
  wire [7:0] next_hi = (wr_en && hit_hi) ? (wr_data & DRIVE_HI_MASK)
                                         : drive_select_hi;
  // Read mux
  wire [7:0] next_rd = hit_lo ? drive_select_lo :
                       hit_hi ? drive_select_hi : READ_NONE;

  // Pin expansion of the next values
  drive_map_if dmap ();
  assign dmap.lo = next_lo;
  assign dmap.hi = next_hi;

  drive_pin_map #(
    .VARIANT (VARIANT)
  ) u_map (
    .m (dmap.map)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Select registers, reset to minimum
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drive_select_lo <= DRIVE_LO_RESET;
      drive_select_hi <= DRIVE_HI_RESET;
    end else begin
      drive_select_lo <= next_lo;
      drive_select_hi <= next_hi;
    end
  end

  // Read data, valid the cycle after the strobe only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data <= READ_NONE;
    end else begin
      rd_data <= rd_en ? next_rd : READ_NONE;
    end
  end

  // Pad levels track the select bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pa_drive <= 8'h00;
      pb_drive <= 8'h00;
      pc_drive <= 8'h00;
      pd_drive <= 8'h00;
      pe_drive <= 8'h00;
      pg_drive <= 8'h00;
    end else begin
      pa_drive <= dmap.pa;
      pb_drive <= dmap.pb;
      pc_drive <= dmap.pc;
      pd_drive <= dmap.pd;
      pe_drive <= dmap.pe;
      pg_drive <= dmap.pg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_write_lo;
    wr_en && hit_lo;
  endsequence
  sequence s_write_hi;
    wr_en && hit_hi;
  endsequence

  a_lo_write_lands: assert property (
    s_write_lo |=> (drive_select_lo == $past(wr_data)))
    else $error("low select not updated by write");

  a_hi_unimpl_zero: assert property (
    s_write_hi |=> ((drive_select_hi & ~DRIVE_HI_MASK) == 8'h00)
                   && (drive_select_hi == ($past(wr_data) & DRIVE_HI_MASK)))
    else $error("high select stored wrong bits");

  a_read_returns: assert property (
    (rd_en && hit_hi && !wr_en) |=> (rd_data == drive_select_hi)
                                    && ((rd_data & ~DRIVE_HI_MASK) == 8'h00))
    else $error("high read data wrong");

  a_read_only_once: assert property (
    !rd_en |=> (rd_data == READ_NONE))
    else $error("read data stands without strobe");

  // Sampled reset keeps the release edge out of the hold check
  a_hold_no_write: assert property (
    (!wr_en && !sys_rst) |=> $stable(drive_select_lo) && $stable(drive_select_hi))
    else $error("select changed without write");

  a_reset_minimum: assert property (
    @(posedge clk) disable iff (1'b0)
    sys_rst |=> (drive_select_lo == 8'h00) && (drive_select_hi == 8'h00)
                && (pb_drive == 8'h00))
    else $error("select not cleared by reset");

  a_pad_a_level: assert property (
    s_write_lo ##1 1'b1 |-> (pa_drive[0] == drive_select_lo[PA_LO_BIT])
                           && (pa_drive[7] == drive_select_lo[PA_HI_BIT]))
    else $error("port A level not following select");

  a_pad_upper: assert property (
    1'b1 |=> ((pd_drive[7] == drive_select_lo[PD_HI_BIT]))
             && ((pb_drive & ~u_map.bond_b) == 8'h00)
             && (pc_drive[4] == drive_select_lo[PC_HI_BIT]))
    else $error("upper group level or bond mask wrong");

  a_pad_g_level: assert property (
    s_write_hi |=> (pg_drive[3:0] == {4{$past(wr_data[PG_LO_BIT])}})
                   && (pe_drive[7:4] == 4'h0)
                   && (pe_drive[0] == $past(wr_data[PE_LO_BIT])))
    else $error("port E or G level wrong");

  //////////////////////////////////////////////////////////////////////////////
  // Reads, refused accesses and full pad words
  sequence s_read_lo;
    rd_en && hit_lo && !wr_en;
  endsequence
  sequence s_write_none;
    wr_en && !hit_lo && !hit_hi && !sys_rst;
  endsequence
  sequence s_read_none;
    rd_en && !hit_lo && !hit_hi;
  endsequence

  a_read_low: assert property (
    s_read_lo |=> (rd_data == drive_select_lo))
    else $error("low read data wrong");

  a_read_unmapped: assert property (
    s_read_none |=> (rd_data == READ_NONE))
    else $error("unmapped read returned data");

  a_write_unmapped: assert property (
    s_write_none |=> $stable(drive_select_lo) && $stable(drive_select_hi))
    else $error("unmapped write changed a select register");

  a_pad_a_word: assert property (
    s_write_lo |=> (pa_drive == {{4{$past(wr_data[PA_HI_BIT])}},
                                 {4{$past(wr_data[PA_LO_BIT])}}}))
    else $error("port A pad word wrong after write");

  a_pad_full_map: assert property (
    s_write_lo |=> (VARIANT != VARIANT_FULL)
                   || ((pb_drive == {{4{$past(wr_data[PB_HI_BIT])}},
                                     {4{$past(wr_data[PB_LO_BIT])}}})
                       && (pc_drive == {{4{$past(wr_data[PC_HI_BIT])}},
                                        {4{$past(wr_data[PC_LO_BIT])}}})
                       && (pd_drive == {{4{$past(wr_data[PD_HI_BIT])}},
                                        {4{$past(wr_data[PD_LO_BIT])}}})))
    else $error("port B, C or D pad word wrong on full variant");

  a_bond_mid: assert property (
    (VARIANT != VARIANT_MID) || (((pb_drive & ~BOND_B_MID) == 8'h00)
                                && ((pc_drive & ~BOND_C_MID) == 8'h00)
                                && ((pd_drive & ~BOND_D_MID) == 8'h00)))
    else $error("unbonded pin driven on mid variant");

  a_bond_small: assert property (
    (VARIANT != VARIANT_SMALL) || (((pb_drive & ~BOND_B_SMALL) == 8'h00)
                                  && ((pc_drive & ~BOND_C_SMALL) == 8'h00)
                                  && ((pd_drive & ~BOND_D_SMALL) == 8'h00)))
    else $error("unbonded pin driven on small variant");

  a_pad_e_g_word: assert property (
    s_write_hi |=> (pg_drive == {{4{$past(wr_data[PG_HI_BIT])}},
                                 {4{$past(wr_data[PG_LO_BIT])}}})
                   && (pe_drive == {4'h0, {4{$past(wr_data[PE_LO_BIT])}}}))
    else $error("port E or G pad word wrong after write");

  a_reset_pads: assert property (
    @(posedge clk) disable iff (1'b0)
    sys_rst |=> (pa_drive == 8'h00) && (pb_drive == 8'h00) && (pc_drive == 8'h00)
                && (pd_drive == 8'h00) && (pe_drive == 8'h00) && (pg_drive == 8'h00)
                && (rd_data == READ_NONE))
    else $error("pad level or read data not cleared by reset");

  a_pads_hold: assert property (
    (!wr_en && !sys_rst) |=> $stable(pa_drive) && $stable(pb_drive) && $stable(pc_drive)
                             && $stable(pd_drive) && $stable(pe_drive) && $stable(pg_drive))
    else $error("pad level changed without write");
endmodule
`default_nettype wire

//--- verification/tb_port_drive_strength_regs.sv
// Self-checking bench for the port drive-strength register bank
`timescale 1ns/1ns
`default_nettype none
module tb_port_drive_strength_regs;
  import drive_pkg::*;
  logic       clk, sys_rst, wr_en, rd_en;
  logic [3:0] addr;
  logic [7:0] wr_data, rd_data, pa, pb, pc, pd, pe, pg;
  logic [7:0] pb_mid, pc_mid, pd_mid, pb_small, pc_small, pd_small;
  int         err_count, n_compared, cycles;

  port_drive_strength_regs dut (.clk(clk), .sys_rst(sys_rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .pa_drive(pa), .pb_drive(pb), .pc_drive(pc), .pd_drive(pd),
    .pe_drive(pe), .pg_drive(pg));
  // Reduced-pin variants share the register port
  port_drive_strength_regs #(.VARIANT(VARIANT_MID)) dut_mid (.clk(clk),
    .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(), .pa_drive(), .pb_drive(pb_mid), .pc_drive(pc_mid), .pd_drive(pd_mid),
    .pe_drive(), .pg_drive());
  port_drive_strength_regs #(.VARIANT(VARIANT_SMALL)) dut_small (.clk(clk),
    .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(), .pa_drive(), .pb_drive(pb_small), .pc_drive(pc_small), .pd_drive(pd_small),
    .pe_drive(), .pg_drive());

  //////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      err_count++;
      conclude();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic conclude();
    $display("Counts: %0d compared, %0d mismatched", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Two select bits spread over a port's nibbles
  function automatic logic [7:0] nib(input logic b0, input logic b1);
    return {{4{b1}}, {4{b0}}};
  endfunction
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wr_data <= d; wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask
  // Read answer in the next cycle only, idle zero after it
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a; rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk("rd_data", exp, rd_data);
    @(posedge clk);
    #1 chk("rd_data idle", 8'h00, rd_data);
  endtask
  task automatic pads(input logic [7:0] lo, input logic [7:0] hi);
    chk("pa_drive", nib(lo[0], lo[1]), pa);
    chk("pb_drive", nib(lo[2], lo[3]), pb);
    chk("pc_drive", nib(lo[4], lo[5]), pc);
    chk("pd_drive", nib(lo[6], lo[7]), pd);
    chk("pe_drive", {4'h0, {4{hi[0]}}}, pe);
    chk("pg_drive", nib(hi[4], hi[5]), pg);
    chk("pb_drive mid", nib(lo[2], lo[3]) & BOND_B_MID, pb_mid);
    chk("pc_drive mid", nib(lo[4], lo[5]) & BOND_C_MID, pc_mid);
    chk("pd_drive mid", nib(lo[6], lo[7]) & BOND_D_MID, pd_mid);
    chk("pb_drive small", nib(lo[2], lo[3]) & BOND_B_SMALL, pb_small);
    chk("pc_drive small", nib(lo[4], lo[5]) & BOND_C_SMALL, pc_small);
    chk("pd_drive small", nib(lo[6], lo[7]) & BOND_D_SMALL, pd_small);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    rd(DRIVE_LO_ADDR, 8'h00);
    rd(DRIVE_HI_ADDR, 8'h00);
    pads(8'h00, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_low();
    for (int i = 0; i < 8; i++) begin
      wr(DRIVE_LO_ADDR, 8'h01 << i);
      pads(8'h01 << i, 8'h00);
      rd(DRIVE_LO_ADDR, 8'h01 << i);
    end
    $display("test low register done");
  endtask
  task automatic t_high();
    wr(DRIVE_HI_ADDR, 8'hFF);
    pads(8'h80, 8'h31);
    rd(DRIVE_HI_ADDR, 8'h31);
    wr(DRIVE_HI_ADDR, 8'hCE);
    pads(8'h80, 8'h00);
    rd(DRIVE_HI_ADDR, 8'h00);
    $display("test high register done");
  endtask
  task automatic t_unmapped();
    wr(DRIVE_HI_ADDR, 8'h11);
    wr(4'h2, 8'hFF);
    wr(4'hF, 8'hFF);
    pads(8'h80, 8'h11);
    rd(4'hF, 8'h00);
    rd(DRIVE_LO_ADDR, 8'h80);
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    #1 pads(8'h00, 8'h00);
    rd(DRIVE_HI_ADDR, 8'h00);
    $display("test unmapped and reset done");
  endtask

  initial begin
    sys_rst = 1'b1; wr_en = 1'b0; rd_en = 1'b0;
    addr = 4'h0; wr_data = 8'h00;
    err_count = 0; n_compared = 0; cycles = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_low();
    t_high();
    t_unmapped();
    conclude();
  end
endmodule
`default_nettype wire
